// file: logic/scp_device.sv
/*
 * Device end: serial shifter on the link clock, register bank and
 * control-pin logic on the sampling clock mclk_in.
 * Assumes the link clock only toggles while select is low.
 */
`timescale 1ns/100ps
module scp_device (
	// serial link
	scp_if.dev link,
	// sampling clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// control pins
	input wire logic ctl_first_in,
	input wire logic ctl_second_in,
	output logic ctl_second_out,
	output logic ctl_second_oe_n_out,
	// datapath status
	input wire logic overrange_in,
	// functions to the datapath
	output logic global_sleep_out,
	output logic sync_ref_out,
	output logic time_stamp_out,
	output logic ext_ref_sel_out,
	output logic osc_switch_out,
	output logic soft_reset_out,
	output logic [scp_pkg::N_REGS*8-1:0] cfg_flat_out
);
	// ---------------- link clock domain ----------------
	logic [4:0] bit_cnt_ff;
	logic [15:0] shift_ff;
	logic [11:0] rd_addr_ff;
	logic rd_mode_ff;
	logic [11:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic wr_tgl_ff;
	logic dout_ff;
	logic dout_oe_n_ff;
	logic [7:0] rd_byte;
	logic [7:0] bank_ff [0:scp_pkg::N_REGS-1];
	logic [7:0] status_byte;
	logic [5:0] rd_idx;

	// config is not frozen while reading: nothing blocks bank updates during a read frame
	// bank indexed right here so the read byte follows every bank update
	// unmapped addresses read zero
	assign rd_idx = scp_pkg::reg_index(rd_addr_ff);
	assign rd_byte = (rd_idx == 6'(scp_pkg::N_REGS)) ? 8'h00 : bank_ff[rd_idx];

	// rising edges: shift in msb first, select high clears the frame
	// select high resets counter
	always_ff @(posedge link.serial_clk or posedge link.serial_select_n) begin
		if (link.serial_select_n) begin
			bit_cnt_ff <= 5'd0;
			shift_ff <= 16'h0000;
			rd_addr_ff <= 12'h000;
			rd_mode_ff <= 1'b0;
		end else begin
			shift_ff <= {shift_ff[14:0], link.serial_io_line};
			if (bit_cnt_ff != scp_pkg::CNT_DONE) begin
				bit_cnt_ff <= bit_cnt_ff + 5'd1;
			end
			if (bit_cnt_ff == scp_pkg::FIRST_DATA_BIT - 5'd1) begin
				rd_addr_ff <= {shift_ff[10:0], link.serial_io_line};
				rd_mode_ff <= shift_ff[14];
			end
		end
	end

	// completed write frame held for the sampling-clock side
	always_ff @(posedge link.serial_clk or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_addr_ff <= 12'h000;
			wr_data_ff <= 8'h00;
			wr_tgl_ff <= 1'b0;
		end else if (!link.serial_select_n && bit_cnt_ff == scp_pkg::LAST_BIT && !rd_mode_ff) begin
			// read frames never post a write
			wr_addr_ff <= rd_addr_ff;
			wr_data_ff <= {shift_ff[6:0], link.serial_io_line};
			wr_tgl_ff <= ~wr_tgl_ff;
		end
	end

	// falling edges: launch read data msb first
	// data changes on falling edge
	always_ff @(negedge link.serial_clk or posedge link.serial_select_n) begin
		if (link.serial_select_n) begin
			dout_ff <= 1'b0;
			dout_oe_n_ff <= 1'b1;
		end else if (rd_mode_ff && bit_cnt_ff >= scp_pkg::FIRST_DATA_BIT && bit_cnt_ff <= scp_pkg::LAST_BIT) begin
			dout_ff <= rd_byte[3'(scp_pkg::LAST_BIT - bit_cnt_ff)];
			dout_oe_n_ff <= 1'b0;
		end else begin
			dout_ff <= 1'b0;
			dout_oe_n_ff <= 1'b1;
		end
	end

	assign link.dev_sdio_out = dout_ff;
	assign link.dev_sdio_oe_n = dout_oe_n_ff;

	// ---------------- sampling clock domain ----------------
	logic [2:0] wr_sync_ff;
	logic [1:0] first_sync_ff;
	logic [1:0] second_sync_ff;
	logic first_prev_ff;
	logic sleep_ff;
	logic sync_det_ff;
	logic soft_rst_ff;
	logic ready_ff;
	logic wr_event;
	logic [5:0] wr_idx;
	logic sync_edge;
	logic pin_sleep;
	logic nxt_sync_det;
	scp_pkg::scp_role_t role_first;
	scp_pkg::scp_role_t role_second;

	// role per pin from the field
	function automatic scp_pkg::scp_role_t pin_role(input logic [4:0] cfg, input logic second);
		case (cfg)
			scp_pkg::PF_SECOND_STAMP: pin_role = second ? scp_pkg::ROLE_STAMP : scp_pkg::ROLE_SYNC;
			scp_pkg::PF_SECOND_EXTREF: pin_role = second ? scp_pkg::ROLE_EXTREF : scp_pkg::ROLE_SYNC;
			scp_pkg::PF_SECOND_SLEEP: pin_role = second ? scp_pkg::ROLE_SLEEP : scp_pkg::ROLE_SYNC;
			scp_pkg::PF_SECOND_OSC: pin_role = second ? scp_pkg::ROLE_OSC : scp_pkg::ROLE_SYNC;
			scp_pkg::PF_SECOND_OVR: pin_role = second ? scp_pkg::ROLE_OVR : scp_pkg::ROLE_SYNC;
			scp_pkg::PF_FIRST_SLEEP: pin_role = second ? scp_pkg::ROLE_NONE : scp_pkg::ROLE_SLEEP;
			scp_pkg::PF_FIRST_SLEEP_OVR: pin_role = second ? scp_pkg::ROLE_OVR : scp_pkg::ROLE_SLEEP;
			// default: sync on first, second idle
			default: pin_role = second ? scp_pkg::ROLE_NONE : scp_pkg::ROLE_SYNC;
		endcase
	endfunction

	// sleep pin chosen by the field
	assign role_first = pin_role(bank_ff[scp_pkg::IDX_PIN_CFG][4:0], 1'b0);
	assign role_second = pin_role(bank_ff[scp_pkg::IDX_PIN_CFG][4:0], 1'b1);
	assign pin_sleep = (role_first == scp_pkg::ROLE_SLEEP && first_sync_ff[1]) ||
		(role_second == scp_pkg::ROLE_SLEEP && second_sync_ff[1]);
	assign wr_event = wr_sync_ff[2] ^ wr_sync_ff[1];
	assign wr_idx = scp_pkg::reg_index(wr_addr_ff);
	assign sync_edge = role_first == scp_pkg::ROLE_SYNC && first_sync_ff[1] && !first_prev_ff;
	// detect flag: a new edge wins over a clear
	assign nxt_sync_det = sync_edge || (sync_det_ff && !bank_ff[scp_pkg::IDX_SYNC_CLR][scp_pkg::POS_SYNC_CLR]);
	assign status_byte = 8'(sync_det_ff) << scp_pkg::POS_SYNC_DET;

	// synchronisers for write toggle and pins
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			wr_sync_ff <= 3'b000;
			first_sync_ff <= 2'b00;
			second_sync_ff <= 2'b00;
			first_prev_ff <= 1'b0;
		end else begin
			wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
			first_sync_ff <= {first_sync_ff[0], ctl_first_in};
			second_sync_ff <= {second_sync_ff[0], ctl_second_in};
			first_prev_ff <= first_sync_ff[1];
		end
	end

	// register bank; soft reset restores defaults one cycle after the write
	// defaults need no programming
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || soft_rst_ff) begin
			for (int i = 0; i < scp_pkg::N_REGS; i++) begin
				bank_ff[i] <= scp_pkg::RST_VAL;
			end
		end else begin
			for (int i = 0; i < scp_pkg::N_REGS; i++) begin
				if (wr_event && wr_idx == 6'(i)) begin
					bank_ff[i] <= wr_data_ff & scp_pkg::REG_MASK[i];
				end
			end
			bank_ff[scp_pkg::IDX_CFG_READY] <= 8'(ready_ff) << scp_pkg::POS_CFG_READY;
			bank_ff[scp_pkg::IDX_SYNC_STATUS] <= status_byte;
		end
	end

	// control state: soft reset pulse, sleep, detect flag, ready
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			soft_rst_ff <= 1'b0;
			sleep_ff <= 1'b0;
			sync_det_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			soft_rst_ff <= wr_event && wr_idx == 6'(scp_pkg::IDX_SOFT_RESET) &&
				wr_data_ff[scp_pkg::POS_SOFT_RESET];
			// sleep only follows a running mclk
			sleep_ff <= bank_ff[scp_pkg::IDX_SLEEP][scp_pkg::POS_SLEEP] || pin_sleep;
			sync_det_ff <= nxt_sync_det;
			ready_ff <= !soft_rst_ff;
		end
	end

	// pin-role outputs, registered
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			sync_ref_out <= 1'b0;
			time_stamp_out <= 1'b0;
			ext_ref_sel_out <= 1'b0;
			osc_switch_out <= 1'b0;
			ctl_second_out <= 1'b0;
			ctl_second_oe_n_out <= 1'b1;
		end else begin
			sync_ref_out <= role_first == scp_pkg::ROLE_SYNC && first_sync_ff[1];
			time_stamp_out <= role_second == scp_pkg::ROLE_STAMP && second_sync_ff[1];
			ext_ref_sel_out <= role_second == scp_pkg::ROLE_EXTREF && second_sync_ff[1];
			osc_switch_out <= role_second == scp_pkg::ROLE_OSC && second_sync_ff[1];
			ctl_second_out <= role_second == scp_pkg::ROLE_OVR && overrange_in;
			ctl_second_oe_n_out <= role_second != scp_pkg::ROLE_OVR;
		end
	end

	assign global_sleep_out = sleep_ff;
	assign soft_reset_out = soft_rst_ff;

	// flattened config view for the datapath
	always_comb begin
		for (int i = 0; i < scp_pkg::N_REGS; i++) begin
			cfg_flat_out[i*8 +: 8] = bank_ff[i];
		end
	end
endmodule

// file: logic/scp_pkg.sv
/*
 * Shared constants for the serial configuration port: register offsets,
 * write masks, reset value, pin-function codes and serial framing counts.
 * Assumes both ends and the bench refer to it as scp_pkg::name.
 */
package scp_pkg;
	// serial frame layout
	localparam int ADDR_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = 24;
	localparam int RW_BIT = 15;
	localparam logic [4:0] LAST_BIT = 5'd23;
	localparam logic [4:0] FIRST_DATA_BIT = 5'd16;
	localparam logic [4:0] CNT_DONE = 5'd24;
	// host serial clock: mclk cycles per half period
	localparam int SCLK_HALF_CYC = 3;

	// register bank
	localparam int N_REGS = 36;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam logic [11:0] REG_ADDR [0:N_REGS-1] = '{
		12'h025, 12'h100, 12'h101, 12'h102, 12'h104, 12'h10A, 12'h10B, 12'h110, 12'h111,
		12'h112, 12'h113, 12'h114, 12'h115, 12'h116, 12'h117, 12'h118, 12'h119, 12'h11A,
		12'h11B, 12'h11C, 12'h11D, 12'h11E, 12'h132, 12'h140, 12'h146, 12'h14A, 12'h14B,
		12'h14C, 12'h14D, 12'h15B, 12'h15C, 12'h160, 12'h161, 12'h162, 12'h163, 12'h164};
	localparam logic [7:0] REG_MASK [0:N_REGS-1] = '{
		8'h00, 8'h01, 8'h10, 8'h40, 8'h03, 8'h07, 8'hFF, 8'hA2, 8'hFF,
		8'hFF, 8'hFE, 8'h01, 8'h0C, 8'hC7, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h00, 8'h1F, 8'h17, 8'hFF,
		8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hDF, 8'hFF, 8'hF9};
	localparam int IDX_CFG_READY = 0;
	localparam int IDX_SOFT_RESET = 1;
	localparam int IDX_SLEEP = 2;
	localparam int IDX_SYNC_CLR = 3;
	localparam int IDX_SYNC_STATUS = 23;
	localparam int IDX_PIN_CFG = 24;
	localparam int POS_CFG_READY = 4;
	localparam int POS_SOFT_RESET = 0;
	localparam int POS_SLEEP = 4;
	localparam int POS_SYNC_CLR = 6;
	localparam int POS_SYNC_DET = 6;

	// pin-function codes
	localparam logic [4:0] PF_DEFAULT = 5'h00;
	localparam logic [4:0] PF_SECOND_STAMP = 5'h01;
	localparam logic [4:0] PF_SECOND_EXTREF = 5'h02;
	localparam logic [4:0] PF_SECOND_SLEEP = 5'h03;
	localparam logic [4:0] PF_SECOND_OSC = 5'h04;
	localparam logic [4:0] PF_SECOND_OVR = 5'h05;
	localparam logic [4:0] PF_FIRST_SLEEP = 5'h0A;
	localparam logic [4:0] PF_FIRST_SLEEP_OVR = 5'h0B;

	typedef enum logic [2:0] {
		ROLE_NONE = 3'b000,
		ROLE_SYNC = 3'b001,
		ROLE_STAMP = 3'b010,
		ROLE_EXTREF = 3'b011,
		ROLE_OSC = 3'b100,
		ROLE_SLEEP = 3'b101,
		ROLE_OVR = 3'b110
	} scp_role_t;

	// bank slot for an address, N_REGS when unmapped
	function automatic logic [5:0] reg_index(input logic [11:0] addr);
		logic [5:0] idx;
		idx = 6'(N_REGS);
		for (int i = 0; i < N_REGS; i++) begin
			if (REG_ADDR[i] == addr) begin
				idx = 6'(i);
			end
		end
		return idx;
	endfunction
endpackage

// file: logic/scp_if.sv
/*
 * Serial link between the external controller and the device end.
 * Resolves the shared data line from both enables; an idle line reads high.
 */
`timescale 1ns/100ps
interface scp_if;
	logic serial_select_n;
	logic serial_clk;
	logic host_sdio_out;
	logic host_sdio_oe_n;
	logic dev_sdio_out;
	logic dev_sdio_oe_n;
	logic serial_io_line;

	// weak pull-up when neither end drives
	assign serial_io_line = !dev_sdio_oe_n ? dev_sdio_out : (!host_sdio_oe_n ? host_sdio_out : 1'b1);

	modport host (output serial_select_n, output serial_clk, output host_sdio_out, output host_sdio_oe_n,
		input serial_io_line);
	modport dev (input serial_select_n, input serial_clk, input serial_io_line, output dev_sdio_out,
		output dev_sdio_oe_n);
endinterface

// file: logic/scp_host.sv
/*
 * Controller end: runs one 24-bit frame per request, making the serial
 * clock from mclk_in by a divider. Assumes the device answers reads on the
 * falling edge that follows the sixteenth address bit.
 */
`timescale 1ns/100ps
module scp_host #(
	parameter int HALF_CYC = scp_pkg::SCLK_HALF_CYC
) (
	// serial link
	scp_if.host link,
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// request
	input wire logic req_valid_in,
	input wire logic req_read_in,
	input wire logic [11:0] req_addr_in,
	input wire logic [7:0] req_data_in,
	output logic req_ready_out,
	// answer
	output logic rsp_valid_out,
	output logic [7:0] rsp_data_out
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SHIFT = 2'b01,
		HS_DONE = 2'b10
	} scp_hstate_t;

	scp_hstate_t state_ff;
	logic [7:0] div_ff;
	logic [4:0] bit_ff;
	logic [23:0] tx_ff;
	logic [7:0] rx_ff;
	logic rd_ff;
	logic sclk_ff;
	logic sel_n_ff;
	logic oe_n_ff;
	logic [1:0] sdio_sync_ff;
	logic phase_end;

	assign phase_end = div_ff == 8'(HALF_CYC - 1);
	assign req_ready_out = state_ff == HS_IDLE;
	assign rsp_valid_out = state_ff == HS_DONE;
	assign rsp_data_out = rx_ff;
	assign link.serial_select_n = sel_n_ff;
	assign link.serial_clk = sclk_ff;
	assign link.host_sdio_out = tx_ff[23];
	assign link.host_sdio_oe_n = oe_n_ff;

	// data line back from the device
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			sdio_sync_ff <= 2'b11;
		end else begin
			sdio_sync_ff <= {sdio_sync_ff[0], link.serial_io_line};
		end
	end

	// frame sequencer
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			state_ff <= HS_IDLE;
			div_ff <= 8'h00;
			bit_ff <= 5'd0;
			tx_ff <= 24'h000000;
			rx_ff <= 8'h00;
			rd_ff <= 1'b0;
			sclk_ff <= 1'b0;
			sel_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else begin
			case (state_ff)
				HS_IDLE: begin
					div_ff <= 8'h00;
					bit_ff <= 5'd0;
					if (req_valid_in) begin
						tx_ff <= {req_read_in, 3'b000, req_addr_in, req_read_in ? 8'h00 : req_data_in};
						rd_ff <= req_read_in;
						sel_n_ff <= 1'b0;
						oe_n_ff <= 1'b0;
						state_ff <= HS_SHIFT;
					end
				end
				HS_SHIFT: begin
					div_ff <= phase_end ? 8'h00 : div_ff + 8'h01;
					if (phase_end) begin
						sclk_ff <= ~sclk_ff;
						if (!sclk_ff && rd_ff && bit_ff >= scp_pkg::FIRST_DATA_BIT) begin
							rx_ff <= {rx_ff[6:0], sdio_sync_ff[1]};
						end
						if (sclk_ff && bit_ff == scp_pkg::LAST_BIT) begin
							sel_n_ff <= 1'b1;
							oe_n_ff <= 1'b1;
							state_ff <= HS_DONE;
						end else if (sclk_ff) begin
							bit_ff <= bit_ff + 5'd1;
							tx_ff <= {tx_ff[22:0], 1'b0};
							oe_n_ff <= rd_ff && (bit_ff + 5'd1) >= scp_pkg::FIRST_DATA_BIT;
						end
					end
				end
				HS_DONE: begin
					state_ff <= HS_IDLE;
				end
				default: begin
					state_ff <= HS_IDLE;
				end
			endcase
		end
	end
endmodule

// file: sim/scp_link_chk.sv
/*
 * Link checker: concurrent checks on the serial frame between both ends.
 * Assumes the bench wires it to the link signals and the sampling clock.
 */
`timescale 1ns/100ps
module scp_link_chk (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// link signals
	input wire logic serial_select_n,
	input wire logic serial_clk,
	input wire logic host_sdio_out,
	input wire logic host_sdio_oe_n,
	input wire logic dev_sdio_out,
	input wire logic dev_sdio_oe_n,
	input wire logic serial_io_line
);
	logic sclk_q_ff;
	logic [5:0] rises_ff;
	logic [5:0] nxt_rises;
	wire sclk_rise = serial_clk && !sclk_q_ff;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	// rising link edges per frame; cleared while select is high
	assign nxt_rises = serial_select_n ? 6'h00 : rises_ff + 6'(sclk_rise);
	always_ff @(posedge mclk_in) begin
		sclk_q_ff <= serial_clk;
		rises_ff <= rstn_in ? nxt_rises : 6'h00;
	end

	a_clk_idle_low: assert property (serial_select_n |-> !serial_clk)
		else $error("link clock not low outside a frame");
	a_sclk_half_period: assert property ($changed(serial_clk) |=> $stable(serial_clk) [*2])
		else $error("link clock half period too short");
	a_frame_bit_count: assert property ($rose(serial_select_n) |-> rises_ff == 6'h18)
		else $error("frame did not carry 24 rising edges");
	a_no_extra_rise: assert property (rises_ff <= 6'h18)
		else $error("more than 24 rising edges in a frame");
	a_rsvd_addr_zero: assert property (sclk_rise && (rises_ff inside {6'h01, 6'h02, 6'h03}) |-> !host_sdio_out)
		else $error("reserved address bit sent as one");
	a_read_turnaround: assert property ($fell(dev_sdio_oe_n) |-> rises_ff == 6'h10 && $rose(host_sdio_oe_n))
		else $error("device took the line at the wrong bit");
	a_no_line_clash: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
		else $error("both ends drive the data line");
	a_dev_launch_fall: assert property (!dev_sdio_oe_n && $changed(dev_sdio_out) |-> $fell(serial_clk))
		else $error("read bit changed off a falling edge");
	a_idle_released: assert property (serial_select_n |-> dev_sdio_oe_n && serial_io_line)
		else $error("data line driven outside a frame");

	// main traffic seen
	cover property ($fell(serial_select_n));
	cover property ($fell(dev_sdio_oe_n));
	cover property ($rose(serial_select_n) && dev_sdio_oe_n);
endmodule

// file: sim/tb_top.sv
/*
 * Bench: host and device ends joined by the link, driven from the host user
 * port and the device pins. Assumes default host divider and 25 MHz clock.
 */
`timescale 1ns/100ps
module tb_top;
	logic mclk_in = 1'b0, rstn_in = 1'b0, clk_run = 1'b1;
	logic req_valid_in = 1'b0, req_read_in = 1'b0, req_ready_out, rsp_valid_out;
	logic [11:0] req_addr_in = 12'h000;
	logic [7:0] req_data_in = 8'h00, rsp_data_out, rd;
	logic ctl_first_in = 1'b0, ctl_second_in = 1'b0, overrange_in = 1'b0;
	logic ctl_second_out, ctl_second_oe_n_out, global_sleep_out, sync_ref_out, time_stamp_out;
	logic ext_ref_sel_out, osc_switch_out, soft_reset_out;
	logic [scp_pkg::N_REGS*8-1:0] cfg_flat_out;
	int mismatches = 0, total_checks = 0, sr_pulses = 0, sr_base = 0, lat = 0;
	// pin roles packed for compact compares; pin drive masked by its enable
	wire [7:0] pins_vec = {1'b0, ctl_second_out & !ctl_second_oe_n_out, global_sleep_out, sync_ref_out,
		time_stamp_out, ext_ref_sel_out, osc_switch_out, ctl_second_oe_n_out};

	scp_if scp_if_inst ();
	scp_host #(.HALF_CYC(scp_pkg::SCLK_HALF_CYC)) scp_host_inst (.link(scp_if_inst.host), .mclk_in(mclk_in),
		.rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_read_in(req_read_in), .req_addr_in(req_addr_in),
		.req_data_in(req_data_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_data_out(rsp_data_out));
	scp_device scp_device_inst (.link(scp_if_inst.dev), .mclk_in(mclk_in), .rstn_in(rstn_in),
		.ctl_first_in(ctl_first_in), .ctl_second_in(ctl_second_in), .ctl_second_out(ctl_second_out),
		.ctl_second_oe_n_out(ctl_second_oe_n_out), .overrange_in(overrange_in),
		.global_sleep_out(global_sleep_out), .sync_ref_out(sync_ref_out), .time_stamp_out(time_stamp_out),
		.ext_ref_sel_out(ext_ref_sel_out), .osc_switch_out(osc_switch_out), .soft_reset_out(soft_reset_out),
		.cfg_flat_out(cfg_flat_out));
	scp_link_chk scp_link_chk_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.serial_select_n(scp_if_inst.serial_select_n), .serial_clk(scp_if_inst.serial_clk),
		.host_sdio_out(scp_if_inst.host_sdio_out), .host_sdio_oe_n(scp_if_inst.host_sdio_oe_n),
		.dev_sdio_out(scp_if_inst.dev_sdio_out), .dev_sdio_oe_n(scp_if_inst.dev_sdio_oe_n),
		.serial_io_line(scp_if_inst.serial_io_line));

	// sampling clock; can be stopped to show sleep needs it
	always #20 mclk_in = clk_run ? !mclk_in : 1'b0;
	// count soft reset pulses
	always @(posedge mclk_in) begin
		if (soft_reset_out === 1'b1) begin
			sr_pulses <= sr_pulses + 1;
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// bounded wait at falling edges: 0 for ready, 1 for answer
	task automatic await(input bit which, output int n);
		n = 0;
		while ((which ? rsp_valid_out : req_ready_out) !== 1'b1) begin
			@(negedge mclk_in);
			n++;
			if (n > 400) begin
				mismatches++;
				$display("wrong value at %0t: handshake timed out", $time);
				final_report();
			end
		end
	endtask

	// one frame; idle spacing after it lets a write land before the next
	task automatic xfer(input logic rnw, input logic [11:0] a, input logic [7:0] d);
		int n;
		await(1'b0, n);
		req_valid_in = 1'b1;
		req_read_in = rnw;
		req_addr_in = a;
		req_data_in = d;
		@(negedge mclk_in);
		req_valid_in = 1'b0;
		await(1'b1, lat);
		// the cycle holding the take edge counts too
		lat = lat + 1;
		rd = rsp_data_out;
		repeat (8) @(negedge mclk_in);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string what);
		xfer(1'b1, a, 8'h00);
		chk(rd, e, what);
	endtask

	task automatic t_defaults();
		for (int i = 0; i < scp_pkg::N_REGS; i++) begin
			rdchk(scp_pkg::REG_ADDR[i], (i == scp_pkg::IDX_CFG_READY) ? 8'h10 : 8'h00, "reset value");
		end
		rdchk(12'h7FF, 8'h00, "unmapped read");
		ctl_first_in = 1'b1;
		ctl_second_in = 1'b1;
		repeat (6) @(negedge mclk_in);
		chk(pins_vec, 8'h11, "default roles");
		ctl_first_in = 1'b0;
		ctl_second_in = 1'b0;
		repeat (6) @(negedge mclk_in);
		$display("test defaults done");
	endtask

	// all ones into every writable slot; read-only and reset slots skipped
	task automatic t_masks();
		for (int i = 0; i < scp_pkg::N_REGS; i++) begin
			if (i != scp_pkg::IDX_CFG_READY && i != scp_pkg::IDX_SOFT_RESET && i != scp_pkg::IDX_SYNC_STATUS) begin
				xfer(1'b0, scp_pkg::REG_ADDR[i], 8'hFF);
				chk(cfg_flat_out[i*8 +: 8], scp_pkg::REG_MASK[i], "bank after write");
				rdchk(scp_pkg::REG_ADDR[i], scp_pkg::REG_MASK[i], "masked read");
				xfer(1'b0, scp_pkg::REG_ADDR[i], 8'h00);
			end
		end
		$display("test masks done");
	endtask

	// asymmetric byte catches bit reversal; read frame must not write
	task automatic t_order();
		xfer(1'b0, 12'h14B, 8'h1E);
		chk(8'(lat), 8'(1 + 48 * scp_pkg::SCLK_HALF_CYC), "answer latency");
		rdchk(12'h14B, 8'h1E, "bit order");
		xfer(1'b1, 12'h14B, 8'hFF);
		chk(cfg_flat_out[26*8 +: 8], 8'h1E, "read frame wrote");
		$display("test order done");
	endtask

	task automatic t_pins();
		logic [4:0] codes [0:7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0A, 5'h0B};
		logic [7:0] hi [0:7] = '{8'h11, 8'h19, 8'h15, 8'h31, 8'h13, 8'h50, 8'h21, 8'h60};
		overrange_in = 1'b1;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 12'h146, {3'h0, codes[i]});
			ctl_first_in = 1'b1;
			ctl_second_in = 1'b1;
			repeat (6) @(negedge mclk_in);
			chk(pins_vec, hi[i], "roles pins high");
			ctl_first_in = 1'b0;
			ctl_second_in = 1'b0;
			repeat (6) @(negedge mclk_in);
			chk(pins_vec, hi[i][0] ? 8'h01 : 8'h40, "roles pins low");
		end
		overrange_in = 1'b0;
		xfer(1'b0, 12'h146, 8'h00);
		rdchk(12'h140, 8'h40, "sync edge seen");
		xfer(1'b0, 12'h102, 8'h40);
		xfer(1'b0, 12'h102, 8'h00);
		rdchk(12'h140, 8'h00, "sync edge cleared");
		$display("test pins done");
	endtask

	// pin sleep with the clock stopped, then register sleep and soft reset
	task automatic t_sleep();
		xfer(1'b0, 12'h146, 8'h03);
		clk_run = 1'b0;
		#100;
		ctl_second_in = 1'b1;
		#410;
		chk(pins_vec & 8'h20, 8'h00, "sleep without clock");
		clk_run = 1'b1;
		repeat (6) @(negedge mclk_in);
		chk(pins_vec & 8'h20, 8'h20, "sleep with clock");
		ctl_second_in = 1'b0;
		xfer(1'b0, 12'h146, 8'h00);
		xfer(1'b0, 12'h101, 8'h10);
		chk(pins_vec & 8'h20, 8'h20, "sleep bit");
		sr_base = sr_pulses;
		xfer(1'b0, 12'h100, 8'h01);
		chk(8'(sr_pulses - sr_base), 8'h01, "soft reset pulse");
		chk(pins_vec & 8'h20, 8'h00, "sleep after reset");
		rdchk(12'h14B, 8'h00, "bank after reset");
		$display("test sleep done");
	endtask

	initial begin
		repeat (8) @(negedge mclk_in);
		rstn_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		t_defaults();
		t_masks();
		t_order();
		t_pins();
		t_sleep();
		final_report();
	end
endmodule
